/* File: bench/osf_host_model.sv */
// Host model: register master on the block's strobe bus
`timescale 1ns/100ps
module osf_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // Released lines show the inverse so a stale value never passes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask : rd
endmodule : osf_host_model

/* File: bench/osf_orientation_properties.sv */
// Checker: port-level properties of the orientation register block
`timescale 1ns/100ps
module osf_orientation_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_sample,
    input wire logic i_irq_enable,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_pulse_highpass_on,
    input wire logic o_pulse_lowpass_on,
    input wire logic [3:0] o_hp_shift,
    input wire logic o_orientation_irq_source
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic rd_st;
    logic rd_cf;
    logic wr_hp;
    assign rd_st = i_ce && i_reg_rd && i_reg_addr == osf_pkg::ADDR_STATUS;
    assign rd_cf = i_ce && i_reg_rd && i_reg_addr == osf_pkg::ADDR_CONFIG;
    assign wr_hp = i_ce && i_reg_wr && i_reg_addr == osf_pkg::ADDR_HP_CUTOFF;
    AST_STATUS_PAD: assert property (rd_st |=> o_reg_rdata[5:3] == 3'h0)
        else $error("status pad bits not zero");
    AST_CONFIG_PAD: assert property (rd_cf |=> o_reg_rdata[5:0] == 6'h00)
        else $error("config pad bits not zero");
    AST_HPF_ON: assert property (wr_hp |-> ##2
        o_pulse_highpass_on == !$past(i_reg_wdata[osf_pkg::BIT_HPF_BYPASS], 2))
        else $error("highpass path does not follow bypass bit");
    AST_LPF_ON: assert property (wr_hp |-> ##2
        o_pulse_lowpass_on == $past(i_reg_wdata[osf_pkg::BIT_LPF_EN], 2))
        else $error("lowpass path does not follow enable bit");
    // A sample one cycle ahead of the read wins, so it is left out
    AST_IRQ_CLEAR: assert property (rd_st && !i_sample && !$past(i_sample)
        |=> !o_orientation_irq_source)
        else $error("status read did not clear interrupt source");
    AST_IRQ_GATE: assert property ((!i_irq_enable)[*2] |=> !o_orientation_irq_source)
        else $error("interrupt source while disabled");
    AST_IRQ_FLAG: assert property (rd_st && i_irq_enable && $past(i_irq_enable)
        ##1 o_reg_rdata[7] |-> $past(o_orientation_irq_source))
        else $error("change flag set without interrupt source");
    AST_RESET_VALUES: assert property ($fell(i_rst) |-> o_pulse_highpass_on
        && !o_pulse_lowpass_on && o_hp_shift == 4'h0 && !o_orientation_irq_source)
        else $error("outputs not at reset values");
    AST_SHIFT_RANGE: assert property (o_hp_shift <= 4'h9)
        else $error("corner below slowest setting");
endmodule : osf_orientation_properties

/* File: bench/osf_orientation_top_tb.sv */
// Testbench: registers, filter controls and orientation status of the block
`timescale 1ns/100ps
module osf_orientation_top_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_sample = 1'b0;
    logic i_raw_facing = 1'b0;
    logic i_raw_lockout = 1'b0;
    logic i_irq_enable = 1'b0;
    logic [1:0] i_raw_code = 2'h0;
    logic [2:0] i_rate = 3'h0;
    osf_pkg::osf_os_e i_os_mode = osf_pkg::OSF_OS_NORMAL;
    logic [7:0] i_dbnc_count = 8'h00;
    logic [9:0] i_mag_x = 10'h000;
    logic [9:0] i_mag_y = 10'h000;
    logic [9:0] i_mag_z = 10'h000;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd_val;
    logic i_reg_wr, i_reg_rd, o_pulse_highpass_on, o_pulse_lowpass_on, o_orientation_irq_source;
    logic [3:0] o_hp_shift;
    int fail_count = 0;
    int checks = 0;
    // Corner table: mode, rate, select, expected shift
    logic [10:0] tbl [9] = '{11'h000, 11'h176, 11'h378, 11'h303, 11'h5f3, 11'h480,
        11'h641, 11'h7f9, 11'h768};
    always #4 i_clk = ~i_clk;
    osf_host_model i_osf_host_model (.i_clk(i_clk), .i_rdata(o_reg_rdata),
        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd));
    osf_orientation_top i_osf_orientation_top (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_wdata(i_reg_wdata), .i_rate(i_rate), .i_os_mode(i_os_mode),
        .i_sample(i_sample), .i_dbnc_count(i_dbnc_count), .i_mag_x(i_mag_x),
        .i_mag_y(i_mag_y), .i_mag_z(i_mag_z), .i_raw_code(i_raw_code),
        .i_raw_facing(i_raw_facing), .i_raw_lockout(i_raw_lockout),
        .i_irq_enable(i_irq_enable), .o_reg_rdata(o_reg_rdata),
        .o_pulse_highpass_on(o_pulse_highpass_on), .o_pulse_lowpass_on(o_pulse_lowpass_on),
        .o_hp_shift(o_hp_shift), .o_orientation_irq_source(o_orientation_irq_source));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : w
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        i_osf_host_model.rd(a, rd_val);
        chk(rd_val, exp);
    endtask : rdc
    task automatic samp(input logic [1:0] c, input logic f, input logic l);
        @(posedge i_clk);
        i_sample <= 1'b1;
        i_raw_code <= c;
        i_raw_facing <= f;
        i_raw_lockout <= l;
        @(posedge i_clk);
        i_sample <= 1'b0;
        w(2);
    endtask : samp
    task automatic t_reset;
        chk({7'h00, o_pulse_highpass_on}, 8'h01);
        chk({7'h00, o_pulse_lowpass_on}, 8'h00);
        chk({4'h0, o_hp_shift}, 8'h00);
        rdc(8'h0f, 8'h00);
        rdc(8'h10, 8'h00);
        rdc(8'h11, 8'h80);
        rdc(8'h20, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        i_osf_host_model.wr(8'h0f, 8'hff);
        w(1);
        chk({7'h00, o_pulse_highpass_on}, 8'h00);
        chk({7'h00, o_pulse_lowpass_on}, 8'h01);
        rdc(8'h0f, 8'h33);
        i_osf_host_model.wr(8'h11, 8'hff);
        rdc(8'h11, 8'hc0);
        i_osf_host_model.wr(8'h10, 8'hff);
        rdc(8'h10, 8'h00);
        i_osf_host_model.wr(8'h11, 8'h80);
        i_osf_host_model.wr(8'h0f, 8'h00);
        w(1);
        chk({7'h00, o_pulse_highpass_on}, 8'h01);
        $display("test registers done");
    endtask : t_regs
    task automatic t_corner;
        for (int i = 0; i < 9; i++)
        begin
            @(posedge i_clk);
            i_os_mode <= osf_pkg::osf_os_e'(tbl[i][10:9]);
            i_rate <= tbl[i][8:6];
            i_osf_host_model.wr(8'h0f, {6'h00, tbl[i][5:4]});
            w(2);
            chk({4'h0, o_hp_shift}, {4'h0, tbl[i][3:0]});
        end
        $display("test corners done");
    endtask : t_corner
    task automatic t_detect;
        samp(2'h2, 1'b0, 1'b0);
        rdc(8'h10, 8'h00);
        i_osf_host_model.wr(8'h11, 8'hc0);
        @(posedge i_clk);
        i_irq_enable <= 1'b1;
        samp(2'h0, 1'b0, 1'b0);
        chk({7'h00, o_orientation_irq_source}, 8'h01);
        rdc(8'h10, 8'h80);
        chk({7'h00, o_orientation_irq_source}, 8'h00);
        rdc(8'h10, 8'h00);
        $display("test detect done");
    endtask : t_detect
    task automatic t_codes;
        logic [1:0] v;
        for (int i = 1; i < 4; i++)
        begin
            v = 2'(i);
            samp(v, v[0], v[1]);
            rdc(8'h10, {1'b1, v[1], 3'h0, v, v[0]});
        end
        samp(2'h1, 1'b0, 1'b0);
        samp(2'h2, 1'b0, 1'b0);
        rdc(8'h10, 8'h84);
        $display("test codes done");
    endtask : t_codes
    task automatic t_lock;
        for (int a = 0; a < 3; a++)
        begin
            @(posedge i_clk);
            i_mag_x <= (a == 0) ? 10'h141 : 10'h000;
            i_mag_y <= (a == 1) ? 10'h141 : 10'h000;
            i_mag_z <= (a == 2) ? 10'h141 : 10'h000;
            samp(2'h3, 1'b0, 1'b0);
            rdc(8'h10, 8'h04);
        end
        @(posedge i_clk);
        i_mag_x <= 10'h140;
        i_mag_y <= 10'h140;
        i_mag_z <= 10'h140;
        samp(2'h3, 1'b0, 1'b0);
        rdc(8'h10, 8'h86);
        $display("test lock done");
    endtask : t_lock
    task automatic t_irq_off;
        @(posedge i_clk);
        i_irq_enable <= 1'b0;
        samp(2'h1, 1'b0, 1'b0);
        chk({7'h00, o_orientation_irq_source}, 8'h00);
        rdc(8'h10, 8'h82);
        $display("test irq off done");
    endtask : t_irq_off
    task automatic t_debounce;
        @(posedge i_clk);
        i_dbnc_count <= 8'h02;
        samp(2'h3, 1'b0, 1'b0);
        samp(2'h3, 1'b0, 1'b0);
        // Lapse after two counts: clear mode restarts, so no update yet
        samp(2'h1, 1'b0, 1'b0);
        samp(2'h3, 1'b0, 1'b0);
        samp(2'h3, 1'b0, 1'b0);
        rdc(8'h10, 8'h02);
        samp(2'h3, 1'b0, 1'b0);
        rdc(8'h10, 8'h86);
        i_osf_host_model.wr(8'h11, 8'h40);
        samp(2'h3, 1'b0, 1'b0);
        samp(2'h2, 1'b0, 1'b0);
        samp(2'h2, 1'b0, 1'b0);
        rdc(8'h10, 8'h84);
        $display("test debounce done");
    endtask : t_debounce
    task automatic t_freeze;
        @(posedge i_clk);
        i_ce <= 1'b0;
        i_osf_host_model.wr(8'h0f, 8'h20);
        w(1);
        chk({7'h00, o_pulse_highpass_on}, 8'h01);
        @(posedge i_clk);
        i_ce <= 1'b1;
        rdc(8'h0f, 8'h02);
        $display("test freeze done");
    endtask : t_freeze
    task automatic conclude;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        w(1);
        t_reset;
        t_regs;
        t_corner;
        t_detect;
        t_codes;
        t_lock;
        t_irq_off;
        t_debounce;
        t_freeze;
        conclude;
    end
    // Whole run is a few hundred cycles; this leaves wide margin
    initial
    begin
        #100000;
        fail_count++;
        conclude;
    end
endmodule : osf_orientation_top_tb
bind osf_orientation_top osf_orientation_properties i_osf_orientation_properties (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .i_sample(i_sample), .i_irq_enable(i_irq_enable), .o_reg_rdata(o_reg_rdata),
    .o_pulse_highpass_on(o_pulse_highpass_on), .o_pulse_lowpass_on(o_pulse_lowpass_on),
    .o_hp_shift(o_hp_shift), .o_orientation_irq_source(o_orientation_irq_source));

/* File: inc/osf_pkg.sv */
// Package: register map, field layout, reset values and modes for the orientation block
//
// Overview of operation
// RQ1: Pulse path uses the high-pass filter when bypass is 0; skips it when 1.
// RQ2: Pulse path low-pass filter inserted only when its enable bit is 1.
// RQ3: Two-bit select field picks the high-pass corner; normal mode 16 Hz down to 0.25 Hz.
// RQ4: Low-noise low-power mode scales corners to 0.5-0.063 Hz at 12.5 Hz and below.
// RQ5: High-res corners fixed 16/8/4/2 Hz; low-power corners fall with rate to 0.031 Hz.
// RQ6: Reading the orientation status clears the change flag and its interrupt source.
// RQ7: Change flag sits in status bit 7; set when facing, orientation or lockout changed.
// RQ8: Lockout bit is 1 when the tilt trip angle is exceeded, else 0.
// RQ9: Orientation code: 00 up, 01 inverted, 10 landscape right, 11 landscape left.
// RQ10: Facing bit is 0 for front and 1 for back.
// RQ11: After reset facing, orientation, lockout and change flag are all zero.
// RQ12: Change flag sets on first detection after activation and on every value change.
// RQ13: Reported values keep updating while the change flag is set.
// RQ14: Reported orientation holds while any axis magnitude exceeds 1.25g.
// RQ15: Config register: debounce mode bit 7, detect enable bit 6, bits 5..0 read zero.
// RQ16: Debounce mode 0 decrements the counter on lapse; mode 1 (default) clears it.
// RQ17: Detection runs only when the enable bit is 1; it resets to 0.
// RQ18: Interrupt source asserts while the change flag is set and the interrupt is enabled.
// RQ19: Writes to status and to unused bits are ignored; unused bits read zero.
package osf_pkg;
    localparam logic [7:0] ADDR_HP_CUTOFF = 8'h0f;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CONFIG = 8'h11;
    localparam int BIT_HPF_BYPASS = 5;
    localparam int BIT_LPF_EN = 4;
    localparam int BIT_SEL_HI = 1;
    localparam int BIT_SEL_LO = 0;
    localparam int BIT_CHANGE = 7;
    localparam int BIT_LOCKOUT = 6;
    localparam int BIT_CODE_HI = 2;
    localparam int BIT_CODE_LO = 1;
    localparam int BIT_FACING = 0;
    localparam int BIT_DBNC_MODE = 7;
    localparam int BIT_DETECT_EN = 6;
    localparam logic [7:0] HP_CUTOFF_WMASK = 8'h33;
    localparam logic [7:0] CONFIG_WMASK = 8'hc0;
    localparam logic [7:0] HP_CUTOFF_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h80;
    localparam logic [1:0] CODE_PORTRAIT_UP = 2'h0;
    localparam logic [1:0] CODE_PORTRAIT_DOWN = 2'h1;
    localparam logic [1:0] CODE_LANDSCAPE_RIGHT = 2'h2;
    localparam logic [1:0] CODE_LANDSCAPE_LEFT = 2'h3;
    localparam logic [0:0] FACING_FRONT = 1'h0;
    localparam logic [0:0] FACING_BACK = 1'h1;
    // Oversampling modes
    typedef enum logic [1:0] {OSF_OS_NORMAL, OSF_OS_LNLP, OSF_OS_HIRES, OSF_OS_LOWPWR} osf_os_e;
    // Rate codes: 0=800 1=400 2=200 3=100 4=50 5=12.5 6=6.25 7=1.56 Hz
    localparam int RATE_W = 3;
    localparam logic [2:0] RATE_400 = 3'h1;
    localparam logic [2:0] RATE_200 = 3'h2;
    localparam logic [2:0] RATE_50 = 3'h4;
    localparam logic [2:0] RATE_12P5 = 3'h5;
    // Corner encoded as log2 shift below 16 Hz: 0=16 Hz ... 9=0.031 Hz
    localparam int SHIFT_W = 4;
    localparam logic [3:0] SHIFT_LNLP_SLOW = 4'h5;
    localparam logic [3:0] SHIFT_LP_SLOW = 4'h6;
    localparam int AXIS_W = 10;
    // 1.25g in counts at the 2g scale (256 counts per g)
    localparam logic [9:0] LOCK_LIMIT = 10'h140;
    localparam int DBNC_W = 8;
endpackage : osf_pkg

/* File: rtl/osf_hp_corner.sv */
// Module: high-pass corner lookup from select code, rate and oversampling mode
`timescale 1ns/100ps
module osf_hp_corner (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [1:0] i_sel,
    input wire logic [osf_pkg::RATE_W-1:0] i_rate,
    input wire osf_pkg::osf_os_e i_os_mode,
    output logic [osf_pkg::SHIFT_W-1:0] o_shift
);
    typedef logic [osf_pkg::SHIFT_W-1:0] osf_shift_t;

    logic [osf_pkg::SHIFT_W-1:0] next_shift;
    logic [osf_pkg::SHIFT_W-1:0] base;
    logic [osf_pkg::SHIFT_W-1:0] sel_ext;

    always_comb
    begin
        sel_ext = {2'h0, i_sel};
        base = '0;
        unique case (i_os_mode)
            osf_pkg::OSF_OS_NORMAL:
            begin
                // Corner falls per rate step down to 50 Hz, then stays put
                if (i_rate <= osf_pkg::RATE_400)
                    base = '0; // [RQ3]
                else if (i_rate < osf_pkg::RATE_50)
                    base = osf_shift_t'(i_rate - osf_pkg::RATE_400);
                else
                    base = osf_shift_t'(osf_pkg::RATE_50 - osf_pkg::RATE_400);
            end
            osf_pkg::OSF_OS_LNLP:
            begin
                if (i_rate <= osf_pkg::RATE_400)
                    base = '0;
                else if (i_rate <= osf_pkg::RATE_50)
                    base = osf_shift_t'(i_rate - osf_pkg::RATE_400);
                else
                    base = osf_pkg::SHIFT_LNLP_SLOW; // [RQ4]
            end
            osf_pkg::OSF_OS_HIRES:
                base = '0; // [RQ5]
            osf_pkg::OSF_OS_LOWPWR:
            begin
                if (i_rate <= osf_pkg::RATE_50)
                    base = {1'h0, i_rate};
                else
                    base = osf_pkg::SHIFT_LP_SLOW; // [RQ5]
            end
        endcase
        next_shift = osf_shift_t'(base + sel_ext); // [RQ3]
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_shift <= '0;
        else if (i_ce)
            o_shift <= next_shift;
    end
endmodule : osf_hp_corner

/* File: rtl/osf_orient_detect.sv */
// Module: orientation change tracking with lock window and debounce
`timescale 1ns/100ps
module osf_orient_detect #(
    parameter int AXIS_W = osf_pkg::AXIS_W,
    parameter int DBNC_W = osf_pkg::DBNC_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_sample,
    input wire logic i_enable,
    input wire logic i_dbnc_mode,
    input wire logic [DBNC_W-1:0] i_dbnc_count,
    input wire logic [AXIS_W-1:0] i_mag_x,
    input wire logic [AXIS_W-1:0] i_mag_y,
    input wire logic [AXIS_W-1:0] i_mag_z,
    input wire logic [1:0] i_raw_code,
    input wire logic i_raw_facing,
    input wire logic i_raw_lockout,
    output logic [1:0] o_code,
    output logic o_facing,
    output logic o_lockout,
    output logic o_changed
);
    logic [DBNC_W-1:0] dbnc;
    logic first_pending;
    logic over_limit;
    logic differs;

    assign over_limit = (i_mag_x > osf_pkg::LOCK_LIMIT[AXIS_W-1:0])
        || (i_mag_y > osf_pkg::LOCK_LIMIT[AXIS_W-1:0])
        || (i_mag_z > osf_pkg::LOCK_LIMIT[AXIS_W-1:0]);
    assign differs = (i_raw_code != o_code) || (i_raw_facing != o_facing)
        || (i_raw_lockout != o_lockout);

    // Debounce counter advances only while a new position is seen
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !i_enable)
            dbnc <= '0;
        else if (i_ce && i_sample)
        begin
            if (differs && !over_limit)
                dbnc <= (dbnc == i_dbnc_count) ? dbnc : DBNC_W'(dbnc + 1'b1);
            else if (i_dbnc_mode)
                dbnc <= '0; // [RQ16]
            else if (dbnc != '0)
                dbnc <= DBNC_W'(dbnc - 1'b1); // [RQ16]
        end
    end

    // First detection after enable must flag even if values did not move
    always_ff @(posedge i_clk)
    begin
        if (i_rst || !i_enable)
            first_pending <= 1'b1;
        else if (i_ce && i_sample && !over_limit)
            first_pending <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_code <= osf_pkg::CODE_PORTRAIT_UP; // [RQ11]
            o_facing <= osf_pkg::FACING_FRONT;
            o_lockout <= 1'b0;
            o_changed <= 1'b0;
        end
        else if (i_ce)
        begin
            o_changed <= 1'b0;
            // Enable gate; over 1.25g the position is held
            if (i_enable && i_sample && !over_limit) // [RQ17] [RQ14]
            begin
                if (differs && dbnc == i_dbnc_count)
                begin
                    o_code <= i_raw_code; // [RQ9] [RQ13]
                    o_facing <= i_raw_facing; // [RQ10]
                    o_lockout <= i_raw_lockout; // [RQ8]
                    o_changed <= 1'b1; // [RQ12]
                end
                else if (first_pending)
                    o_changed <= 1'b1; // [RQ12]
            end
        end
    end
endmodule : osf_orient_detect

/* File: rtl/osf_orientation_top.sv */
// Module: register file and filter controls of the orientation and pulse filter block
`timescale 1ns/100ps
module osf_orientation_top #(
    parameter int AXIS_W = osf_pkg::AXIS_W,
    parameter int DBNC_W = osf_pkg::DBNC_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [osf_pkg::RATE_W-1:0] i_rate,
    input wire osf_pkg::osf_os_e i_os_mode,
    input wire logic i_sample,
    input wire logic [DBNC_W-1:0] i_dbnc_count,
    input wire logic [AXIS_W-1:0] i_mag_x,
    input wire logic [AXIS_W-1:0] i_mag_y,
    input wire logic [AXIS_W-1:0] i_mag_z,
    input wire logic [1:0] i_raw_code,
    input wire logic i_raw_facing,
    input wire logic i_raw_lockout,
    input wire logic i_irq_enable,
    output logic [7:0] o_reg_rdata,
    output logic o_pulse_highpass_on,
    output logic o_pulse_lowpass_on,
    output logic [osf_pkg::SHIFT_W-1:0] o_hp_shift,
    output logic o_orientation_irq_source
);
    logic [7:0] highpass_cutoff_select;
    logic [7:0] orientation_config;
    logic orientation_change_flag;
    logic [1:0] orientation_code;
    logic facing_bit;
    logic tilt_lockout;
    logic changed;
    logic status_read;
    logic [7:0] status_word;

    function automatic logic [7:0] masked(input logic [7:0] d, input logic [7:0] m);
        masked = d & m;
    endfunction : masked

    assign status_read = i_ce && i_reg_rd && (i_reg_addr == osf_pkg::ADDR_STATUS);
    always_comb
    begin
        status_word = '0; // [RQ19]
        status_word[osf_pkg::BIT_CHANGE] = orientation_change_flag; // [RQ7]
        status_word[osf_pkg::BIT_LOCKOUT] = tilt_lockout;
        status_word[osf_pkg::BIT_CODE_HI:osf_pkg::BIT_CODE_LO] = orientation_code;
        status_word[osf_pkg::BIT_FACING] = facing_bit;
    end

    // Only writable bits are kept; status ignores writes
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            highpass_cutoff_select <= osf_pkg::HP_CUTOFF_RESET; // [RQ1] [RQ2] [RQ3]
        else if (i_ce && i_reg_wr && i_reg_addr == osf_pkg::ADDR_HP_CUTOFF)
            highpass_cutoff_select <= masked(i_reg_wdata, osf_pkg::HP_CUTOFF_WMASK); // [RQ19]
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            orientation_config <= osf_pkg::CONFIG_RESET; // [RQ16] [RQ17]
        else if (i_ce && i_reg_wr && i_reg_addr == osf_pkg::ADDR_CONFIG)
            orientation_config <= masked(i_reg_wdata, osf_pkg::CONFIG_WMASK); // [RQ15]
    end

    // Set wins over a read in the same cycle so no change is lost
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            orientation_change_flag <= 1'b0; // [RQ11]
        else if (i_ce)
        begin
            if (changed)
                orientation_change_flag <= 1'b1; // [RQ12]
            else if (status_read)
                orientation_change_flag <= 1'b0; // [RQ6]
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_reg_rdata <= '0;
        else if (i_ce && i_reg_rd)
        begin
            unique case (i_reg_addr)
                osf_pkg::ADDR_HP_CUTOFF: o_reg_rdata <= highpass_cutoff_select;
                osf_pkg::ADDR_STATUS: o_reg_rdata <= status_word;
                osf_pkg::ADDR_CONFIG: o_reg_rdata <= orientation_config; // [RQ15]
                default: o_reg_rdata <= '0;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_pulse_highpass_on <= 1'b1;
            o_pulse_lowpass_on <= 1'b0;
        end
        else if (i_ce)
        begin
            o_pulse_highpass_on <= !highpass_cutoff_select[osf_pkg::BIT_HPF_BYPASS]; // [RQ1]
            o_pulse_lowpass_on <= highpass_cutoff_select[osf_pkg::BIT_LPF_EN]; // [RQ2]
        end
    end

    // Interrupt source follows the flag; cleared with it on a status read
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_orientation_irq_source <= 1'b0;
        else if (i_ce)
            o_orientation_irq_source <= (changed || (orientation_change_flag && !status_read))
                && i_irq_enable; // [RQ18] [RQ6]
    end

    osf_hp_corner u_corner (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_sel(highpass_cutoff_select[osf_pkg::BIT_SEL_HI:osf_pkg::BIT_SEL_LO]),
        .i_rate(i_rate),
        .i_os_mode(i_os_mode),
        .o_shift(o_hp_shift)
    );

    osf_orient_detect #(
        .AXIS_W(AXIS_W),
        .DBNC_W(DBNC_W)
    ) u_detect (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_sample(i_sample),
        .i_enable(orientation_config[osf_pkg::BIT_DETECT_EN]),
        .i_dbnc_mode(orientation_config[osf_pkg::BIT_DBNC_MODE]),
        .i_dbnc_count(i_dbnc_count),
        .i_mag_x(i_mag_x),
        .i_mag_y(i_mag_y),
        .i_mag_z(i_mag_z),
        .i_raw_code(i_raw_code),
        .i_raw_facing(i_raw_facing),
        .i_raw_lockout(i_raw_lockout),
        .o_code(orientation_code),
        .o_facing(facing_bit),
        .o_lockout(tilt_lockout),
        .o_changed(changed)
    );
endmodule : osf_orientation_top
